// *** scpm_top.sv ***
`timescale 1ns/1ps

module scpm_top #(
	parameter int WD_BASE_TICKS = 2048,
	parameter int WD_W = 21
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// pins and neighbours
	input wire logic [7:0] factory_trim_in,
	input wire logic clock_ready_in,
	input wire logic wdt_osc_tick_in,
	input wire logic reset_cause_wdog_in,
	input wire logic timer_ext_clk_req_in,
	input wire logic timer_ext_lf_req_in,
	// divided clock enables
	output logic clk_cpu_en_out,
	output logic clk_io_en_out,
	output logic clk_adc_en_out,
	output logic clk_flash_en_out,
	// oscillator trim
	output logic trim_range_select_out,
	output logic [6:0] trim_fine_value_out,
	// clock sources
	output logic ext_clk_en_out,
	output logic ext_lf_osc_en_out,
	output logic ext_xtal_en_out,
	output logic clk_out_en_out,
	output logic [3:0] src_cmd_out,
	output logic src_cmd_strobe_out,
	// watchdog
	output logic wd_reset_out,
	output logic wd_timeout_irq_out
);

	// synchronisers for every pin input
	logic [7:0] trim_s1_r, trim_s2_r;
	logic [4:0] pin_s1_r, pin_s2_r;
	logic tick_d_r;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			trim_s1_r <= 8'h00;
			trim_s2_r <= 8'h00;
			pin_s1_r <= 5'h00;
			pin_s2_r <= 5'h00;
			tick_d_r <= 1'b0;
		end else begin
			trim_s1_r <= factory_trim_in;
			trim_s2_r <= trim_s1_r;
			pin_s1_r <= {timer_ext_lf_req_in, timer_ext_clk_req_in, reset_cause_wdog_in,
				clock_ready_in, wdt_osc_tick_in};
			pin_s2_r <= pin_s1_r;
			tick_d_r <= pin_s2_r[0];
		end
	end
	wire wd_tick = pin_s2_r[0] & ~tick_d_r;
	wire clk_rdy_s = pin_s2_r[1];
	wire watchdog_reset_cause_flag_s = pin_s2_r[2];
	wire tmr_clk_req = pin_s2_r[3];
	wire tmr_lf_req = pin_s2_r[4];

	// ahb-lite: zero wait states, always okay
	logic dp_wr_r, dp_rd_r;
	logic [7:0] dp_addr_r;
	// hsize is ignored: every register is one whole word
	wire ap_valid = hsel_in & htrans_in[1] & hready_in;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dp_wr_r <= 1'b0;
			dp_rd_r <= 1'b0;
			dp_addr_r <= 8'h00;
		end else begin
			dp_wr_r <= ap_valid & hwrite_in;
			dp_rd_r <= ap_valid & ~hwrite_in;
			if (ap_valid) begin
				dp_addr_r <= haddr_in[7:0];
			end
		end
	end
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	wire [7:0] wd8 = hwdata_in[7:0];
	wire wr_trim = dp_wr_r & (dp_addr_r == scpm_pkg::OFF_TRIM);
	wire wr_div = dp_wr_r & (dp_addr_r == scpm_pkg::OFF_DIV);
	wire wr_cmd = dp_wr_r & (dp_addr_r == scpm_pkg::OFF_CMD);
	wire wr_csel = dp_wr_r & (dp_addr_r == scpm_pkg::OFF_CSEL);
	wire wr_wdctl = dp_wr_r & (dp_addr_r == scpm_pkg::OFF_WDCTL);
	wire wr_wdrld = dp_wr_r & (dp_addr_r == scpm_pkg::OFF_WDRLD);

	// oscillator trim, loaded from the factory value once the sync settles
	logic [7:0] trim_r;
	logic [1:0] trim_ld_r;
	wire trim_load = (trim_ld_r == scpm_pkg::TRIM_LOAD_CYC);
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			trim_r <= 8'h00;
			trim_ld_r <= 2'h0;
		end else begin
			if (trim_ld_r != 2'h3) begin
				trim_ld_r <= trim_ld_r + 2'h1;
			end
			if (trim_load) begin
				trim_r <= trim_s2_r;
			end else if (wr_trim) begin
				trim_r <= wd8;
			end
		end
	end
	// the oscillator maps range and fine value; 0x7f sits above 0x80
	assign trim_range_select_out = trim_r[scpm_pkg::TRIM_RANGE_BIT];
	assign trim_fine_value_out = trim_r[6:0];

	// prescaler state, declared ahead of the divider that reads its wrap
	logic [8:0] pre_cnt_r;
	logic [3:0] div_act_r;
	logic pre_tick_r;
	wire [8:0] pre_term = (9'h001 << div_act_r) - 9'h001;
	wire pre_wrap = (pre_cnt_r == pre_term);

	// divider control with timed protected write
	logic [2:0] pce_cnt_r;
	logic [3:0] div_code_r;
	logic div_pend_r;
	wire pce_open = (pce_cnt_r != 3'h0);
	wire div_arm = wr_div & (wd8 == scpm_pkg::CE_ONLY) & ~pce_open;
	wire div_take = wr_div & ~wd8[scpm_pkg::CE_BIT] & pce_open;
	wire div_legal = (wd8[3:0] <= scpm_pkg::DIV_MAX_CODE);
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pce_cnt_r <= 3'h0;
			div_code_r <= scpm_pkg::DIV_RESET;
			div_pend_r <= 1'b0;
		end else begin
			if (div_arm) begin
				pce_cnt_r <= scpm_pkg::WIN_CYC;
			end else if (div_take) begin
				pce_cnt_r <= 3'h0;
			end else if (pce_open) begin
				pce_cnt_r <= pce_cnt_r - 3'h1;
			end
			// other writes leave the field as is
			if (div_take & div_legal) begin
				div_code_r <= wd8[3:0];
				div_pend_r <= 1'b1;
			end else if (pre_wrap) begin
				div_pend_r <= 1'b0;
			end
		end
	end

	// prescaler: the running factor only changes at a period boundary,
	// so the last old period and the first new one are both whole;
	// an accepted write restarts the count, so the new rate is active one
	// whole old period after it
	wire pre_restart = div_take & div_legal;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pre_cnt_r <= 9'h000;
			div_act_r <= scpm_pkg::DIV_RESET;
			pre_tick_r <= 1'b0;
		end else begin
			pre_tick_r <= pre_wrap;
			if (pre_restart) begin
				pre_cnt_r <= 9'h000;
			end else if (pre_wrap) begin
				pre_cnt_r <= 9'h000;
				if (div_pend_r) begin
					div_act_r <= div_code_r;
				end
			end else begin
				pre_cnt_r <= pre_cnt_r + 9'h001;
			end
		end
	end
	assign clk_cpu_en_out = pre_tick_r;
	assign clk_io_en_out = pre_tick_r;
	assign clk_adc_en_out = pre_tick_r;
	assign clk_flash_en_out = pre_tick_r;

	// clock selection; bit 7 is reserved and always reads zero
	logic [7:0] csel_r;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			csel_r <= scpm_pkg::CSEL_RESET;
		end else if (wr_csel) begin
			csel_r <= {1'b0, wd8[6:0]};
		end
	end

	// clock command register with the same protected write
	logic [2:0] cce_cnt_r;
	logic [3:0] cmd_r;
	logic cmd_stb_r;
	wire cce_open = (cce_cnt_r != 3'h0);
	wire cmd_arm = wr_cmd & (wd8 == scpm_pkg::CE_ONLY) & ~cce_open;
	wire cmd_take = wr_cmd & ~wd8[scpm_pkg::CE_BIT] & cce_open;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cce_cnt_r <= 3'h0;
			cmd_r <= scpm_pkg::CMD_NONE;
			cmd_stb_r <= 1'b0;
		end else begin
			// codes 8 to 15 are kept but start nothing
			cmd_stb_r <= cmd_take & ~wd8[3];
			if (cmd_arm) begin
				cce_cnt_r <= scpm_pkg::WIN_CYC;
			end else if (cmd_take) begin
				cce_cnt_r <= 3'h0;
			end else if (cce_open) begin
				cce_cnt_r <= cce_cnt_r - 3'h1;
			end
			if (cmd_take) begin
				cmd_r <= wd8[3:0];
			end
		end
	end
	wire cmd_go = cmd_stb_r;
	wire is_en = cmd_go & (cmd_r == scpm_pkg::CMD_ENABLE);
	wire is_dis = cmd_go & (cmd_r == scpm_pkg::CMD_DISABLE);
	wire is_auto = cmd_go & (cmd_r == scpm_pkg::CMD_WD_AUTO);
	wire is_cout = cmd_go & (cmd_r == scpm_pkg::CMD_CLKOUT);
	assign src_cmd_out = cmd_r;
	assign src_cmd_strobe_out = cmd_go;

	// external source enables
	logic [2:0] ext_sel_r;
	logic [2:0] ext_en_r;
	logic cout_r;
	wire [3:0] cs = csel_r[3:0];
	wire [2:0] cs_hit = {cs == scpm_pkg::SRC_EXT_XTAL, cs == scpm_pkg::SRC_EXT_LF,
		cs == scpm_pkg::SRC_EXT_CLK};
	wire [2:0] ext_req = ext_sel_r | {1'b0, tmr_lf_req, tmr_clk_req};
	wire [2:0] ext_one;
	// fixed priority: two timer requests never enable two sources
	assign ext_one[0] = ext_req[0];
	assign ext_one[1] = ext_req[1] & ~ext_req[0];
	assign ext_one[2] = ext_req[2] & ~ext_req[1] & ~ext_req[0];
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ext_sel_r <= 3'h0;
			ext_en_r <= 3'h0;
			cout_r <= 1'b0;
		end else begin
			ext_en_r <= ext_one;
			if (is_en & (cs_hit != 3'h0)) begin
				ext_sel_r <= cs_hit;
			end else if (is_dis) begin
				ext_sel_r <= ext_sel_r & ~cs_hit;
			end
			if (is_cout) begin
				cout_r <= csel_r[scpm_pkg::CSEL_COUT_BIT];
			end
		end
	end
	assign ext_clk_en_out = ext_en_r[0];
	assign ext_lf_osc_en_out = ext_en_r[1];
	assign ext_xtal_en_out = ext_en_r[2];
	assign clk_out_en_out = cout_r;

	// watchdog
	scpm_pkg::scpm_wd_mode_e wd_mode_r, wd_mode_nxt;
	logic [7:0] wdctl_r;
	logic [WD_W-1:0] wd_cnt_r;
	logic wd_rst_r, wd_irq_r;
	wire wd_auto = (wd_mode_r == scpm_pkg::WD_AUTO);
	// prescale codes above nine saturate at the longest timeout
	wire [3:0] presc = (wdctl_r[3:0] > scpm_pkg::WD_PRESC_MAX) ? scpm_pkg::WD_PRESC_MAX :
		wdctl_r[3:0];
	wire [WD_W-1:0] wd_limit = WD_W'(WD_BASE_TICKS) << presc;
	wire soft_on = wdctl_r[scpm_pkg::WD_RST_EN_BIT] | wdctl_r[scpm_pkg::WD_IRQ_EN_BIT];
	// a tick seen here proves the system clock runs; only valid while it is
	// at least four times the watchdog rate
	wire hw_reload = wd_auto & wd_tick;
	wire sw_reload = wr_wdrld & ~wd_auto;
	wire wd_hit = (wd_mode_r != scpm_pkg::WD_OFF) & wd_tick & (wd_cnt_r >= wd_limit);
	// the auto command's own cycle already blocks the interrupt
	wire irq_block = wd_auto | is_auto;
	always_comb begin
		wd_mode_nxt = wd_mode_r;
		case (wd_mode_r)
			scpm_pkg::WD_OFF: begin
				if (is_auto) begin
					wd_mode_nxt = scpm_pkg::WD_AUTO;
				end else if (soft_on) begin
					wd_mode_nxt = scpm_pkg::WD_SOFT;
				end
			end
			scpm_pkg::WD_SOFT: begin
				if (is_auto) begin
					wd_mode_nxt = scpm_pkg::WD_AUTO;
				end else if (!soft_on) begin
					wd_mode_nxt = scpm_pkg::WD_OFF;
				end
			end
			scpm_pkg::WD_AUTO: begin
				wd_mode_nxt = scpm_pkg::WD_AUTO;
			end
			default: begin
				wd_mode_nxt = scpm_pkg::WD_OFF;
			end
		endcase
	end
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wd_mode_r <= scpm_pkg::WD_OFF;
			wdctl_r <= scpm_pkg::WDCTL_RESET;
			wd_cnt_r <= '0;
			wd_rst_r <= 1'b0;
			wd_irq_r <= 1'b0;
		end else begin
			wd_mode_r <= wd_mode_nxt;
			if (wr_wdctl) begin
				wdctl_r <= {2'h0, wd8[5:0]};
			end
			if (sw_reload | hw_reload | wd_hit | (wd_mode_r == scpm_pkg::WD_OFF)) begin
				wd_cnt_r <= '0;
			end else if (wd_tick) begin
				wd_cnt_r <= wd_cnt_r + WD_W'(1);
			end
			wd_rst_r <= wd_hit & (wd_auto | wdctl_r[scpm_pkg::WD_RST_EN_BIT]);
			wd_irq_r <= wd_hit & ~irq_block & wdctl_r[scpm_pkg::WD_IRQ_EN_BIT];
		end
	end
	assign wd_reset_out = wd_rst_r;
	assign wd_timeout_irq_out = wd_irq_r;

	// read-back; the prescaler count stays hidden
	wire [7:0] rd_div = {pce_open, 3'h0, div_code_r};
	wire [7:0] rd_cmd = {cce_open, 2'h0, clk_rdy_s, cmd_r};
	wire [7:0] rd_stat = {5'h00, clk_rdy_s, wd_auto, watchdog_reset_cause_flag_s};
	// unmapped offsets read zero
	wire [7:0] rd_sel = (dp_addr_r == scpm_pkg::OFF_TRIM) ? trim_r :
		(dp_addr_r == scpm_pkg::OFF_DIV) ? rd_div :
		(dp_addr_r == scpm_pkg::OFF_CMD) ? rd_cmd :
		(dp_addr_r == scpm_pkg::OFF_CSEL) ? csel_r :
		(dp_addr_r == scpm_pkg::OFF_WDCTL) ? {wd_auto, 1'b0, wdctl_r[5:0]} :
		(dp_addr_r == scpm_pkg::OFF_STAT) ? rd_stat : 8'h00;
	assign hrdata_out = dp_rd_r ? {24'h00_0000, rd_sel} : 32'h0000_0000;

endmodule

// *** scpm_pkg.sv ***
package scpm_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_TRIM = 8'h00;
	localparam logic [7:0] OFF_DIV = 8'h04;
	localparam logic [7:0] OFF_CMD = 8'h08;
	localparam logic [7:0] OFF_CSEL = 8'h0C;
	localparam logic [7:0] OFF_WDCTL = 8'h10;
	localparam logic [7:0] OFF_WDRLD = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;

	// field positions
	localparam int CE_BIT = 7;
	localparam int TRIM_RANGE_BIT = 7;
	localparam int WD_RST_EN_BIT = 4;
	localparam int WD_IRQ_EN_BIT = 5;
	localparam int CSEL_COUT_BIT = 6;

	// reset values and the change-enable-only arm pattern
	localparam logic [3:0] DIV_RESET = 4'h0;
	localparam logic [7:0] CSEL_RESET = 8'h00;
	localparam logic [7:0] WDCTL_RESET = 8'h00;
	localparam logic [7:0] CE_ONLY = 8'h80;

	// division field
	localparam logic [3:0] DIV_MAX_CODE = 4'h8;

	// protected-write window, in system clock cycles
	localparam logic [2:0] WIN_CYC = 3'h4;

	// trim capture delay: two synchroniser stages settle first
	localparam logic [1:0] TRIM_LOAD_CYC = 2'h2;

	// clock commands
	localparam logic [3:0] CMD_NONE = 4'h0;
	localparam logic [3:0] CMD_DISABLE = 4'h1;
	localparam logic [3:0] CMD_ENABLE = 4'h2;
	localparam logic [3:0] CMD_AVAIL = 4'h3;
	localparam logic [3:0] CMD_SWITCH = 4'h4;
	localparam logic [3:0] CMD_RECOVER = 4'h5;
	localparam logic [3:0] CMD_WD_AUTO = 4'h6;
	localparam logic [3:0] CMD_CLKOUT = 4'h7;

	// source-select codes of the three external sources (plain defaults)
	localparam logic [3:0] SRC_EXT_CLK = 4'h0;
	localparam logic [3:0] SRC_EXT_LF = 4'h6;
	localparam logic [3:0] SRC_EXT_XTAL = 4'h8;

	// watchdog prescale
	localparam logic [3:0] WD_PRESC_MAX = 4'h9;

	typedef enum logic [1:0] {
		WD_OFF,
		WD_SOFT,
		WD_AUTO
	} scpm_wd_mode_e;

endpackage

// *** scpm_top_props.sv ***
`timescale 1ns/1ps
module scpm_top_props (
	// clock, reset, bus
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	// outputs watched
	input wire logic clk_cpu_en_out,
	input wire logic clk_io_en_out,
	input wire logic clk_adc_en_out,
	input wire logic clk_flash_en_out,
	input wire logic trim_range_select_out,
	input wire logic [6:0] trim_fine_value_out,
	input wire logic ext_clk_en_out,
	input wire logic ext_lf_osc_en_out,
	input wire logic ext_xtal_en_out,
	input wire logic [3:0] src_cmd_out,
	input wire logic src_cmd_strobe_out,
	input wire logic wd_timeout_irq_out
);
	logic dp_q, dw_q, auto_q;
	logic [7:0] da_q;
	logic [2:0] since_q;
	wire rd_div = dp_q & ~dw_q & (da_q == scpm_pkg::OFF_DIV);
	wire ce_wr = dp_q & dw_q & (da_q == scpm_pkg::OFF_DIV) & (hwdata_in[7:0] == 8'h80);
	// data-phase tracker; since_q saturates so it never wraps back into range
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dp_q <= 1'b0;
			dw_q <= 1'b0;
			da_q <= 8'h00;
			auto_q <= 1'b0;
			since_q <= 3'h7;
		end else begin
			dp_q <= hsel_in & htrans_in[1] & hready_in;
			dw_q <= hwrite_in;
			da_q <= haddr_in[7:0];
			auto_q <= auto_q | (src_cmd_strobe_out & (src_cmd_out == scpm_pkg::CMD_WD_AUTO));
			since_q <= ce_wr ? 3'h0 : since_q + {2'h0, since_q != 3'h7};
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	clk_en_same_a: assert property ({clk_io_en_out, clk_adc_en_out, clk_flash_en_out} == {3{clk_cpu_en_out}})
		else $error("divided clock enables differ");
	one_source_a: assert property ($onehot0({ext_clk_en_out, ext_lf_osc_en_out, ext_xtal_en_out}))
		else $error("two external sources enabled");
	trim_write_a: assert property (dp_q && dw_q && da_q == scpm_pkg::OFF_TRIM |=>
		{trim_range_select_out, trim_fine_value_out} == $past(hwdata_in[7:0])) else $error("trim not applied");
	res_zero_a: assert property (rd_div |-> hrdata_out[6:4] == 3'h0)
		else $error("reserved divider bits set");
	ce_window_a: assert property (rd_div && hrdata_out[7] |-> since_q <= 3'h3)
		else $error("change window open too long");
	cmd_strobe_a: assert property (src_cmd_strobe_out |-> !src_cmd_out[3] ##1 !src_cmd_strobe_out)
		else $error("bad command strobe");
	auto_quiet_a: assert property (auto_q |-> !wd_timeout_irq_out)
		else $error("interrupt in auto mode");
	auto_stat_a: assert property (auto_q && dp_q && !dw_q && da_q == scpm_pkg::OFF_STAT |-> hrdata_out[1])
		else $error("auto mode left");
endmodule
bind scpm_top scpm_top_props i_scpm_top_props (.clk_sys_in, .resetn_in, .hsel_in, .haddr_in,
	.htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .clk_cpu_en_out, .clk_io_en_out,
	.clk_adc_en_out, .clk_flash_en_out, .trim_range_select_out, .trim_fine_value_out,
	.ext_clk_en_out, .ext_lf_osc_en_out, .ext_xtal_en_out, .src_cmd_out, .src_cmd_strobe_out,
	.wd_timeout_irq_out);

// *** test_sys_clock_prescaler_monitor.sv ***
`timescale 1ns/1ps
module test_sys_clock_prescaler_monitor;
	logic clk_sys_in = 1'b0, resetn_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
	logic [31:0] haddr_in = 32'h0000_0000, hwdata_in = 32'h0000_0000, rd_q, got;
	logic [1:0] htrans_in = 2'h0;
	logic clock_ready_in = 1'b1, reset_cause_wdog_in = 1'b1, wdt_osc_tick_in = 1'b0;
	logic timer_ext_clk_req_in = 1'b0, timer_ext_lf_req_in = 1'b0;
	logic [2:0] tdiv = 3'h0;
	logic [3:0] srcs [3] = '{scpm_pkg::SRC_EXT_CLK, scpm_pkg::SRC_EXT_LF, scpm_pkg::SRC_EXT_XTAL};
	wire logic [31:0] hrdata_out;
	wire logic [6:0] trim_fine_value_out;
	wire logic [3:0] src_cmd_out;
	wire logic hreadyout_out, clk_cpu_en_out, trim_range_select_out, src_cmd_strobe_out;
	wire logic ext_clk_en_out, ext_lf_osc_en_out, ext_xtal_en_out, wd_reset_out, wd_timeout_irq_out;
	wire logic clk_out_en_out;
	int bad_count = 0, n_compared = 0, n_irq = 0, n_rst = 0, n_stb = 0, k, j;
	// small timeout base keeps the watchdog scenarios short
	scpm_top #(.WD_BASE_TICKS(4), .WD_W(21)) i_scpm_top (.clk_sys_in, .resetn_in, .hsel_in,
		.haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
		.hrdata_out, .hreadyout_out, .hresp_out(), .factory_trim_in(8'h5A), .clock_ready_in,
		.wdt_osc_tick_in, .reset_cause_wdog_in, .timer_ext_clk_req_in, .timer_ext_lf_req_in,
		.clk_cpu_en_out, .clk_io_en_out(), .clk_adc_en_out(), .clk_flash_en_out(),
		.trim_range_select_out, .trim_fine_value_out, .ext_clk_en_out, .ext_lf_osc_en_out,
		.ext_xtal_en_out, .clk_out_en_out, .src_cmd_out, .src_cmd_strobe_out, .wd_reset_out,
		.wd_timeout_irq_out);
	initial forever #10 clk_sys_in = ~clk_sys_in;
	// watchdog tick at one eighth of the system clock
	always @(posedge clk_sys_in) begin
		tdiv <= tdiv + 3'h1;
		wdt_osc_tick_in <= tdiv[2];
		rd_q <= hrdata_out;
		n_irq <= n_irq + int'(wd_timeout_irq_out);
		n_rst <= n_rst + int'(wd_reset_out);
		n_stb <= n_stb + int'(src_cmd_strobe_out);
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys_in);
		hsel_in <= 1'b1;
		haddr_in <= {24'h00_0000, a};
		htrans_in <= 2'h2;
		hwrite_in <= w;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
		#1 got = rd_q;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0000_0000);
		chk(got, e);
	endtask
	task prot(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, 32'h0000_0080);
		xfer(a, 1'b1, d);
	endtask
	// spacing between enable pulses, after the change has settled
	task meas(input int c);
		repeat (3) begin
			@(posedge clk_sys_in);
			while (clk_cpu_en_out !== 1'b1) @(posedge clk_sys_in);
		end
		k = 0;
		do begin
			@(posedge clk_sys_in);
			k++;
		end while (clk_cpu_en_out !== 1'b1);
		chk(32'(k), 32'h0000_0001 << c);
	endtask
	task final_report;
		$display("mismatches %0d comparisons %0d", bad_count, n_compared);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rd(scpm_pkg::OFF_TRIM, 32'h0000_005A);
		rd(scpm_pkg::OFF_DIV, 32'h0000_0000);
		xfer(scpm_pkg::OFF_TRIM, 1'b1, 32'h0000_007F);
		chk({trim_range_select_out, trim_fine_value_out}, 32'h0000_007F);
		xfer(scpm_pkg::OFF_TRIM, 1'b1, 32'h0000_0080);
		chk({trim_range_select_out, trim_fine_value_out}, 32'h0000_0080);
		prot(scpm_pkg::OFF_DIV, 32'h0000_0073);
		rd(scpm_pkg::OFF_DIV, 32'h0000_0003);
		xfer(scpm_pkg::OFF_DIV, 1'b1, 32'h0000_0080);
		rd(scpm_pkg::OFF_DIV, 32'h0000_0083);
		xfer(scpm_pkg::OFF_DIV, 1'b1, 32'h0000_0005);
		xfer(scpm_pkg::OFF_DIV, 1'b1, 32'h0000_0081);
		xfer(scpm_pkg::OFF_DIV, 1'b1, 32'h0000_0005);
		xfer(scpm_pkg::OFF_DIV, 1'b1, 32'h0000_0080);
		xfer(scpm_pkg::OFF_DIV, 1'b1, 32'h0000_0080);
		xfer(scpm_pkg::OFF_DIV, 1'b1, 32'h0000_0005);
		prot(scpm_pkg::OFF_DIV, 32'h0000_0009);
		rd(scpm_pkg::OFF_DIV, 32'h0000_0003);
		for (int c = 0; c <= 8; c++) begin
			prot(scpm_pkg::OFF_DIV, 32'(c));
			meas(c);
		end
		for (int c = 0; c <= 8; c++) begin
			if (c != 6) begin
				j = n_stb;
				prot(scpm_pkg::OFF_CMD, 32'(c));
				repeat (3) @(posedge clk_sys_in);
				chk(32'(src_cmd_out), 32'(c));
				chk(32'(n_stb - j), 32'(c < 8));
			end
		end
		for (int s = 0; s < 3; s++) begin
			xfer(scpm_pkg::OFF_CSEL, 1'b1, {28'h000_0000, srcs[s]});
			prot(scpm_pkg::OFF_CMD, 32'(scpm_pkg::CMD_ENABLE));
			repeat (4) @(posedge clk_sys_in);
			chk({ext_clk_en_out, ext_lf_osc_en_out, ext_xtal_en_out}, 3'b100 >> s);
		end
		timer_ext_lf_req_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		chk({ext_clk_en_out, ext_lf_osc_en_out, ext_xtal_en_out}, 32'h0000_0002);
		timer_ext_lf_req_in <= 1'b0;
		xfer(scpm_pkg::OFF_CSEL, 1'b1, 32'h0000_0040);
		prot(scpm_pkg::OFF_CMD, 32'(scpm_pkg::CMD_CLKOUT));
		repeat (2) @(posedge clk_sys_in);
		chk(32'(clk_out_en_out), 32'h0000_0001);
		rd(scpm_pkg::OFF_STAT, 32'h0000_0005);
		xfer(scpm_pkg::OFF_WDCTL, 1'b1, 32'h0000_0030);
		k = n_irq;
		j = n_rst;
		repeat (200) @(posedge clk_sys_in);
		// prescale 0: timeout on every fifth tick, so four or five in 200 cycles
		k = n_irq - k;
		j = n_rst - j;
		chk(32'(k inside {[4:5]} && j inside {[4:5]}), 32'h0000_0001);
		xfer(scpm_pkg::OFF_WDRLD, 1'b1, 32'h0000_0000);
		repeat (2) @(posedge clk_sys_in);
		k = n_irq;
		repeat (20) xfer(scpm_pkg::OFF_WDRLD, 1'b1, 32'h0000_0000);
		chk(32'(n_irq - k), 32'h0000_0000);
		prot(scpm_pkg::OFF_CMD, 32'(scpm_pkg::CMD_WD_AUTO));
		repeat (4) @(posedge clk_sys_in);
		prot(scpm_pkg::OFF_CMD, 32'(scpm_pkg::CMD_SWITCH));
		chk(32'(src_cmd_out), 32'(scpm_pkg::CMD_SWITCH));
		k = n_irq;
		j = n_rst;
		repeat (200) @(posedge clk_sys_in);
		chk(32'(n_irq - k), 32'h0000_0000);
		chk(32'(n_rst - j), 32'h0000_0000);
		xfer(scpm_pkg::OFF_WDCTL, 1'b1, 32'h0000_0000);
		rd(scpm_pkg::OFF_WDCTL, 32'h0000_0080);
		rd(scpm_pkg::OFF_STAT, 32'h0000_0007);
		@(posedge clk_sys_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rd(scpm_pkg::OFF_STAT, 32'h0000_0005);
		rd(scpm_pkg::OFF_TRIM, 32'h0000_005A);
		final_report();
	end
	initial begin
		#400000;
		bad_count++;
		final_report();
	end
endmodule
